// ==== xcvr_pkg.sv ====
// constants of the module control block and its pin input synchroniser
//
// What this block does
// - fault output high on laser fault detection
// - laser off while disable high or open
// - receive rate select, low when undriven
// - transmit rate select, low when undriven
// - presence contact tied low, host sees low
// - loss-of-signal high on weak optical input
// - laser below 10% within 100 us
// - laser back on within 2 ms
// - serial interface ready within 300 ms
// - non-cooled part operational within 300 ms
// - cooled part operational within 90 s
// - non-cooled high power settles within 300 ms
// - low power limits within 300 ms
// - disable held 10 us clears fault
// - cooled part flags fault within 50 ms
// - loss-of-signal follows input within 100 us
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// package
package xcvr_pkg;
  // system clock rate
  localparam longint unsigned CLK_HZ       = 20_000_000;
  // times in their own units, as specified
  localparam longint unsigned T_RESET_US   = 10;    // least disable hold to clear fault
  localparam longint unsigned T_INIT_MS    = 300;   // non-cooled start-up bound
  localparam longint unsigned T_SERIAL_MS  = 300;   // serial interface start-up bound
  localparam longint unsigned T_PWR_UP_MS  = 300;   // non-cooled power level raise bound
  localparam longint unsigned T_COOLED_S   = 90;    // cooled start-up and raise bound
  // cycle counts: least times round up, longest times round down
  localparam longint unsigned T_RESET_CYC  = (T_RESET_US * CLK_HZ + 999_999) / 1_000_000;
  localparam longint unsigned T_INIT_CYC   = T_INIT_MS * CLK_HZ / 1000;
  localparam longint unsigned T_SERIAL_CYC = T_SERIAL_MS * CLK_HZ / 1000;
  localparam longint unsigned T_PWR_UP_CYC = T_PWR_UP_MS * CLK_HZ / 1000;
  localparam longint unsigned T_COOLED_CYC = T_COOLED_S * CLK_HZ;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_IRQ_STS = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h10;

  // control register fields and reset value
  localparam int         CTRL_W      = 2;
  localparam int         CTRL_COOLED = 0;
  localparam int         CTRL_HIPWR  = 1;
  localparam logic [1:0] CTRL_RST    = 2'h0;

  // status register fields
  localparam int ST_FAULT  = 0;
  localparam int ST_LOS    = 1;
  localparam int ST_LASER  = 2;
  localparam int ST_SERIAL = 3;
  localparam int ST_READY  = 4;
  localparam int ST_HIPWR  = 5;
  localparam int ST_RXRATE = 6;
  localparam int ST_TXRATE = 7;
  localparam int ST_STATE  = 8;

  // interrupt status, clear and enable fields
  localparam int         IRQ_W       = 4;
  localparam int         IRQ_FAULT   = 0;
  localparam int         IRQ_LOS     = 1;
  localparam int         IRQ_READY   = 2;
  localparam int         IRQ_PWR     = 3;
  localparam logic [3:0] IRQ_EN_RST  = 4'h0;

  // pin sampler reset levels: disable idles high, others low
  localparam int         PIN_W       = 5;
  localparam int         PIN_DIS     = 0;
  localparam int         PIN_RXRATE  = 1;
  localparam int         PIN_TXRATE  = 2;
  localparam int         PIN_FAULT   = 3;
  localparam int         PIN_LOW     = 4;
  localparam logic [4:0] PIN_RST     = 5'h01;

  // bus transfer type bit that marks an active transfer
  localparam int HTRANS_ACT = 1;

  // module sequencing states, gray coded along init, run, raise
  typedef enum logic [1:0]
  {
    S_INIT  = 2'b00,
    S_RUN   = 2'b01,
    S_UPPWR = 2'b11,
    S_FAULT = 2'b10
  } mstate_t;

  // register hit decode, used by both the read and the write path
  function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] off);
    return (a[7:0] == off) && (a[31:8] == 24'h000000);
  endfunction
endpackage

// ============================================================
// three flop sampler for inputs from outside the clock domain
module pin_sync
#(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] d_out
);
  genvar i;
  // one sampler per bit; a change is taken once stages two and three agree
  for (i = 0; i < W; i++)
  begin : g_bit
    logic s1_r;   // first stage, read only by the second
    logic s2_r;   // second stage
    logic s3_r;   // third stage
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        s1_r     <= RST_VAL[i];
        s2_r     <= RST_VAL[i];
        s3_r     <= RST_VAL[i];
        d_out[i] <= RST_VAL[i];
      end
      else
      begin
        s1_r <= d_in[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        // agreement filter: a one-cycle glitch never reaches the output
        if (s2_r == s3_r)
        begin
          d_out[i] <= s3_r;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ==== xcvr_ctrl.sv ====
// top of the pluggable module control block with its register slave
`timescale 1ns/1ps
`default_nettype none

module xcvr_ctrl
  import xcvr_pkg::*;
#(
  parameter logic [31:0] INIT_CYC   = 32'(T_INIT_CYC),    // non-cooled start-up count
  parameter logic [31:0] SERIAL_CYC = 32'(T_SERIAL_CYC),  // serial interface start-up count
  parameter logic [31:0] PWR_UP_CYC = 32'(T_PWR_UP_CYC),  // non-cooled power raise count
  parameter logic [31:0] COOLED_CYC = 32'(T_COOLED_CYC)   // cooled start-up and raise count
)(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // module pins and analog monitor flags
  input  wire logic        tx_disable_pin,
  input  wire logic        receive_rate_select,
  input  wire logic        transmit_rate_select,
  input  wire logic        laser_fault_det,
  input  wire logic        rx_signal_low,
  output var  logic        tx_fault_o,
  output var  logic        tx_fault_oe,
  output var  logic        rx_los_o,
  output var  logic        rx_los_oe,
  output var  logic        module_absent_o,
  output var  logic        module_absent_oe,
  output var  logic        laser_on,
  output var  logic        rx_rate_sel,
  output var  logic        tx_rate_sel,
  output var  logic        high_power_on,
  output var  logic        serial_ready,
  output var  logic        module_ready,
  output var  logic        irq,
  // register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp
);

  // ============================================================
  // reset release
  logic rst_s1_r;   // first release stage
  logic rst_n_s;    // released reset used by the whole block

  // assert at once, release through two flops to avoid a ragged exit
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_r <= 1'b0;
      rst_n_s  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_s  <= rst_s1_r;
    end
  end

  // ============================================================
  // pin sampling
  logic [PIN_W-1:0] pins_s;   // filtered pin levels
  logic             tx_dis_s; // disable level, high while open
  logic             fault_s;  // laser fault detected
  logic             low_s;    // optical level under threshold

  // disable resets high so the laser stays dark until the pin is seen
  pin_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_pins
  (
    .clk   (clk_sys),
    .rst_n (rst_n_s),
    .d_in  ({rx_signal_low, laser_fault_det, transmit_rate_select,
             receive_rate_select, tx_disable_pin}),
    .d_out (pins_s)
  );

  assign tx_dis_s = pins_s[PIN_DIS];
  assign fault_s  = pins_s[PIN_FAULT];
  assign low_s    = pins_s[PIN_LOW];

  // ============================================================
  // bus address phase and decode
  logic              take;        // address phase accepted this cycle
  logic              wr_pend_r;   // write data phase pending
  logic [31:0]       wr_addr_r;   // address of the pending write
  logic [CTRL_W-1:0] ctrl_r;      // cooled flag and high power request
  logic [IRQ_W-1:0]  irq_sts_r;   // sticky event bits
  logic [IRQ_W-1:0]  irq_en_r;    // event enables
  logic [IRQ_W-1:0]  irq_clr;     // write-one-to-clear strobes
  logic [IRQ_W-1:0]  ev;          // events of this cycle
  logic [31:0]       status;      // live status word
  logic [31:0]       rd_mux;      // read data for the address in phase
  logic              fault_r;     // latched fault
  logic              rx_los_r;    // loss-of-signal level
  logic              laser_on_r;  // laser drive enable
  logic              hp_act_r;    // higher power level in force
  logic              ser_rdy_r;   // serial interface ready
  logic              mod_rdy_r;   // module fully operational
  mstate_t           state_r;     // sequencing state
  mstate_t           state_nxt;   // next sequencing state

  assign take = hsel && htrans[HTRANS_ACT] && hready;

  // hsize is not checked: only whole words are mapped
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h00000000;
    end
    else
    begin
      wr_pend_r <= take && hwrite;
      if (take)
      begin
        wr_addr_r <= haddr;
      end
    end
  end

  // status word shows the block's own state
  always_comb
  begin
    status            = 32'h00000000;
    status[ST_FAULT]  = fault_r;
    status[ST_LOS]    = rx_los_r;
    status[ST_LASER]  = laser_on_r;
    status[ST_SERIAL] = ser_rdy_r;
    status[ST_READY]  = mod_rdy_r;
    status[ST_HIPWR]  = hp_act_r;
    status[ST_RXRATE] = pins_s[PIN_RXRATE];
    status[ST_TXRATE] = pins_s[PIN_TXRATE];
    status[ST_STATE +: 2] = state_r;
  end

  // read mux; unmapped and write-only offsets read as zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (addr_hit(haddr, OFF_CTRL))
    begin
      rd_mux[CTRL_W-1:0] = ctrl_r;
    end
    else if (addr_hit(haddr, OFF_STATUS))
    begin
      rd_mux = status;
    end
    else if (addr_hit(haddr, OFF_IRQ_STS))
    begin
      rd_mux[IRQ_W-1:0] = irq_sts_r;
    end
    else if (addr_hit(haddr, OFF_IRQ_EN))
    begin
      rd_mux[IRQ_W-1:0] = irq_en_r;
    end
  end

  // read data is sampled in the address phase so it leaves a flop
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;   // zero wait states, always OKAY
      hresp     <= 1'b0;
      if (take && !hwrite)
      begin
        hrdata <= rd_mux;
      end
    end
  end

  // ============================================================
  // register writes
  // control and enable registers take hwdata in the data phase
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      ctrl_r   <= CTRL_RST;
      irq_en_r <= IRQ_EN_RST;
    end
    else if (wr_pend_r)
    begin
      if (addr_hit(wr_addr_r, OFF_CTRL))
      begin
        ctrl_r <= hwdata[CTRL_W-1:0];
      end
      if (addr_hit(wr_addr_r, OFF_IRQ_EN))
      begin
        irq_en_r <= hwdata[IRQ_W-1:0];
      end
    end
  end

  assign irq_clr = (wr_pend_r && addr_hit(wr_addr_r, OFF_IRQ_CLR)) ?
                   hwdata[IRQ_W-1:0] : '0;

  // ============================================================
  // fault latch
  localparam int            RCW     = $clog2(int'(T_RESET_CYC) + 1);
  localparam logic [RCW-1:0] RST_HOLD = RCW'(T_RESET_CYC);
  logic [RCW-1:0] dis_cnt_r;   // cycles the disable has been held high
  logic           fault_clr;   // disable held long enough

  // saturating hold counter, restarts on every low level
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      dis_cnt_r <= '0;
    end
    else if (!tx_dis_s)
    begin
      dis_cnt_r <= '0;
    end
    else if (dis_cnt_r != RST_HOLD)
    begin
      dis_cnt_r <= dis_cnt_r + 1'b1;
    end
  end

  assign fault_clr = tx_dis_s && (dis_cnt_r == RST_HOLD);

  // latched well inside the 50 ms bound; a live fault beats the clear
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      fault_r <= 1'b0;
    end
    else if (fault_s)
    begin
      fault_r <= 1'b1;
    end
    else if (fault_clr)
    begin
      fault_r <= 1'b0;
    end
  end

  // ============================================================
  // sequencing of start-up, power level and fault recovery
  logic [31:0] cnt_r;      // settle counter of the current state
  logic [31:0] lim_init;   // start-up length for this part
  logic [31:0] lim_pwr;    // power raise length for this part
  logic        cnt_done;   // settle count reached

  assign lim_init = ctrl_r[CTRL_COOLED] ? COOLED_CYC : INIT_CYC;
  assign lim_pwr  = ctrl_r[CTRL_COOLED] ? COOLED_CYC : PWR_UP_CYC;
  assign cnt_done = (state_r == S_INIT) ? (cnt_r >= lim_init - 32'h1) :
                                          (cnt_r >= lim_pwr - 32'h1);

  // next state; a fault always wins, recovery restarts the start-up
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      S_INIT:
      begin
        if (fault_r)
          state_nxt = S_FAULT;
        else if (!tx_dis_s && cnt_done)
          state_nxt = S_RUN;
      end
      S_RUN:
      begin
        if (fault_r)
          state_nxt = S_FAULT;
        else if (ctrl_r[CTRL_HIPWR] && !hp_act_r)
          state_nxt = S_UPPWR;
      end
      S_UPPWR:
      begin
        if (fault_r)
          state_nxt = S_FAULT;
        else if (!ctrl_r[CTRL_HIPWR] || cnt_done)
          state_nxt = S_RUN;
      end
      S_FAULT:
      begin
        if (!fault_r)
          state_nxt = S_INIT;
      end
    endcase
  end

  // settle counter; held at zero while disabled during power-up
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      state_r <= S_INIT;
      cnt_r   <= 32'h00000000;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt != state_r || (state_r == S_INIT && tx_dis_s))
        cnt_r <= 32'h00000000;
      else if (!cnt_done)
        cnt_r <= cnt_r + 32'h1;
    end
  end

  // power level: raised after settling, dropped on the next cycle
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      hp_act_r <= 1'b0;
    end
    else if (!ctrl_r[CTRL_HIPWR])
    begin
      hp_act_r <= 1'b0;
    end
    else if (state_r == S_UPPWR && state_nxt == S_RUN)
    begin
      hp_act_r <= 1'b1;
    end
  end

  // ready flags; the serial count runs once per reset
  logic [31:0] ser_cnt_r;   // serial start-up counter
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      ser_cnt_r <= 32'h00000000;
      ser_rdy_r <= 1'b0;
      mod_rdy_r <= 1'b0;
    end
    else
    begin
      mod_rdy_r <= (state_nxt == S_RUN) || (state_nxt == S_UPPWR);
      if (ser_cnt_r >= SERIAL_CYC - 32'h1)
        ser_rdy_r <= 1'b1;
      else
        ser_cnt_r <= ser_cnt_r + 32'h1;
    end
  end

  // ============================================================
  // pin drivers
  // laser dark on disable, fault or before ready; sampler lag is 3-4 cycles
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      laser_on_r  <= 1'b0;
      rx_los_r    <= 1'b0;
      rx_rate_sel <= 1'b0;
      tx_rate_sel <= 1'b0;
    end
    else
    begin
      laser_on_r  <= !tx_dis_s && !fault_s && !fault_r &&
                     (state_r == S_RUN || state_r == S_UPPWR);
      rx_los_r    <= low_s;
      rx_rate_sel <= pins_s[PIN_RXRATE];
      tx_rate_sel <= pins_s[PIN_TXRATE];
    end
  end

  // open-drain pins pull low only while their level is low
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      tx_fault_o       <= 1'b0;
      tx_fault_oe      <= 1'b1;
      rx_los_o         <= 1'b0;
      rx_los_oe        <= 1'b1;
      module_absent_o  <= 1'b0;
      module_absent_oe <= 1'b1;
    end
    else
    begin
      tx_fault_o       <= 1'b0;
      tx_fault_oe      <= !fault_r;
      rx_los_o         <= 1'b0;
      rx_los_oe        <= !rx_los_r;
      module_absent_o  <= 1'b0;
      module_absent_oe <= 1'b1;
    end
  end

  assign laser_on      = laser_on_r;
  assign high_power_on = hp_act_r;
  assign serial_ready  = ser_rdy_r;
  assign module_ready  = mod_rdy_r;

  // ============================================================
  // interrupts
  assign ev[IRQ_FAULT] = fault_s && !fault_r;
  assign ev[IRQ_LOS]   = low_s != rx_los_r;
  assign ev[IRQ_READY] = (state_r == S_INIT) && (state_nxt == S_RUN);
  assign ev[IRQ_PWR]   = (state_r == S_UPPWR) && (state_nxt == S_RUN) && ctrl_r[CTRL_HIPWR];

  // an event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      irq_sts_r <= '0;
      irq       <= 1'b0;
    end
    else
    begin
      irq_sts_r <= (irq_sts_r & ~irq_clr) | ev;
      irq       <= |(irq_sts_r & irq_en_r);
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_s);

  fault_raise_a: assert property (fault_s |=> fault_r ##1 !tx_fault_oe)
    else $error("fault not raised on the pin");
  laser_dark_a: assert property (tx_dis_s |=> !laser_on_r)
    else $error("laser on while disabled");
  rate_follow_a: assert property (##1 rx_rate_sel == $past(pins_s[PIN_RXRATE]))
    else $error("receive rate select not followed");
  tx_rate_a: assert property (##1 tx_rate_sel == $past(pins_s[PIN_TXRATE]))
    else $error("transmit rate select not followed");
  absent_tie_a: assert property (module_absent_oe && !module_absent_o)
    else $error("presence contact released");
  los_track_a: assert property ($changed(low_s) |-> ##[1:2] rx_los_oe == !low_s)
    else $error("loss of signal pin late");
  laser_back_a: assert property ($fell(tx_dis_s) && state_r == S_RUN && !fault_r
                                 && !fault_s |=> laser_on_r)
    else $error("laser not back on");
  serial_bound_a: assert property (!ser_rdy_r |-> ser_cnt_r < SERIAL_CYC)
    else $error("serial ready late");
  init_bound_a: assert property (state_r == S_INIT |-> cnt_r < lim_init)
    else $error("start-up overruns its bound");
  raise_bound_a: assert property (state_r == S_UPPWR |-> cnt_r < lim_pwr)
    else $error("power raise overruns its bound");
  power_drop_a: assert property ($fell(ctrl_r[CTRL_HIPWR]) |-> ##[0:1] !hp_act_r)
    else $error("high power not dropped");
  fault_hold_a: assert property (fault_r && !fault_clr |=> fault_r)
    else $error("fault dropped without reset");
  fault_clear_a: assert property (fault_clr && !fault_s |=> !fault_r ##1 tx_fault_oe)
    else $error("fault not cleared");

  fault_cycle_c: cover property (fault_r ##[1:300] !fault_r);
  power_up_c:    cover property (state_r == S_UPPWR ##1 hp_act_r);
  los_seen_c:    cover property ($rose(rx_los_r));
  ready_c:       cover property ($rose(mod_rdy_r));

endmodule

`default_nettype wire

// ==== host_model.sv ====
// host board side of the module pins: pull-ups and the disable drive
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic flt_o,
  input  wire logic flt_oe,
  input  wire logic los_o,
  input  wire logic los_oe,
  input  wire logic abs_o,
  input  wire logic abs_oe,
  input  wire logic dis_val,
  input  wire logic dis_oe,
  output var  logic flt_pin,
  output var  logic los_pin,
  output var  logic abs_pin,
  output var  logic dis_pin
);
  // ============================================================
  // wired levels
  // a released open drain line floats up to the host pull-up
  assign flt_pin = flt_oe ? flt_o : 1'b1;
  assign los_pin = los_oe ? los_o : 1'b1;
  // high on the presence contact reads as an empty slot
  assign abs_pin = abs_oe ? abs_o : 1'b1;
  // an undriven disable line is lifted by the module pull-up
  assign dis_pin = dis_oe ? dis_val : 1'b1;
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the module control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import xcvr_pkg::*;
  // ============================================================
  // signals
  localparam int INIT_N = 20;  // shortened start-up count
  localparam int PWR_N  = 20;  // shortened power raise count
  localparam int COOL_N = 40;  // shortened cooled count
  typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        dis_val = 1'b0, dis_oe = 1'b1, dis_pin;
  logic        rx_sel = 1'b0, tx_sel = 1'b0, flt_det = 1'b0, sig_low = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        flt_o, flt_oe, los_o, los_oe, abs_o, abs_oe, flt_pin, los_pin, abs_pin;
  logic        laser_on, rx_rate_sel, tx_rate_sel, high_power_on, serial_ready, module_ready;
  int          n_mismatch = 0, total_checks = 0, n;
  // register rows: write flag, address, write data, expected read back
  row_t        rows [7] = '{
    '{1'b0, 32'(OFF_CTRL), 32'h0, 32'h0},
    '{1'b0, 32'(OFF_IRQ_EN), 32'h0, 32'h0},
    '{1'b1, 32'(OFF_IRQ_EN), 32'hffffffff, 32'hf},
    '{1'b1, 32'h14, 32'hffffffff, 32'h0},
    '{1'b1, 32'h100, 32'hffffffff, 32'h0},
    '{1'b0, 32'(OFF_CTRL), 32'h0, 32'h0},
    '{1'b1, 32'(OFF_IRQ_CLR), 32'h0, 32'h0}};

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  // ============================================================
  // design and host board
  xcvr_ctrl #(.INIT_CYC(32'(INIT_N)), .SERIAL_CYC(32'd10), .PWR_UP_CYC(32'(PWR_N)),
    .COOLED_CYC(32'(COOL_N))) i_dut (.clk_sys(clk_sys), .rstn(rstn),
    .tx_disable_pin(dis_pin), .receive_rate_select(rx_sel), .transmit_rate_select(tx_sel),
    .laser_fault_det(flt_det), .rx_signal_low(sig_low), .tx_fault_o(flt_o),
    .tx_fault_oe(flt_oe), .rx_los_o(los_o), .rx_los_oe(los_oe), .module_absent_o(abs_o),
    .module_absent_oe(abs_oe), .laser_on(laser_on), .rx_rate_sel(rx_rate_sel),
    .tx_rate_sel(tx_rate_sel), .high_power_on(high_power_on), .serial_ready(serial_ready),
    .module_ready(module_ready), .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  host_model i_host (.flt_o(flt_o), .flt_oe(flt_oe), .los_o(los_o), .los_oe(los_oe),
    .abs_o(abs_o), .abs_oe(abs_oe), .dis_val(dis_val), .dis_oe(dis_oe), .flt_pin(flt_pin),
    .los_pin(los_pin), .abs_pin(abs_pin), .dis_pin(dis_pin));

  // ============================================================
  // helpers
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single-word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask
  // bounded wait for ready, laser or high power
  task automatic wait_hi(input int s, input int lim);
    n = 0;
    while ((s == 0 ? module_ready : s == 1 ? laser_on : high_power_on) !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ============================================================
  // main sequence
  initial
  begin
    cyc(20);
    chk("flt_rst", flt_pin, 32'h0);
    rstn <= 1'b1;
    wait_hi(0, INIT_N + 20);
    chk("ready", module_ready, 32'h1);
    chk("serial", serial_ready, 32'h1);
    chk("absent", abs_pin, 32'h0);
    foreach (rows[i])
    begin
      if (rows[i].w)
        bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk("reg", rd, rows[i].e);
    end
    for (int k = 0; k < 4; k++)
    begin
      rx_sel <= k[0];
      tx_sel <= k[1];
      cyc(6);
      chk("rx_rate", rx_rate_sel, 32'(k[0]));
      chk("tx_rate", tx_rate_sel, 32'(k[1]));
    end
    sig_low <= 1'b1;
    cyc(8);
    chk("los_on", los_pin, 32'h1);
    sig_low <= 1'b0;
    cyc(8);
    chk("los_off", los_pin, 32'h0);
    dis_val <= 1'b1;
    cyc(8);
    chk("dis_hi", laser_on, 32'h0);
    dis_oe <= 1'b0;
    cyc(8);
    chk("dis_open", laser_on, 32'h0);
    dis_oe <= 1'b1;
    dis_val <= 1'b0;
    wait_hi(1, 100);
    chk("dis_lo", laser_on, 32'h1);
    bus(1'b1, 32'(OFF_CTRL), 32'h2);
    wait_hi(2, PWR_N + 10);
    chk("hipwr", high_power_on, 32'h1);
    bus(1'b1, 32'(OFF_CTRL), 32'h0);
    cyc(2);
    chk("lopwr", high_power_on, 32'h0);
    bus(1'b1, 32'(OFF_CTRL), 32'h3);
    wait_hi(2, COOL_N + 10);
    chk("hipwr_c", high_power_on, 32'h1);
    // fault with its interrupt masked, then enabled, then cleared
    bus(1'b1, 32'(OFF_IRQ_CLR), 32'hf);
    bus(1'b1, 32'(OFF_IRQ_EN), 32'h0);
    flt_det <= 1'b1;
    cyc(8);
    chk("flt_on", flt_pin, 32'h1);
    chk("flt_laser", laser_on, 32'h0);
    chk("irq_mask", irq, 32'h0);
    flt_det <= 1'b0;
    bus(1'b0, 32'(OFF_IRQ_STS), 32'h0);
    chk("sts", rd & 32'h1, 32'h1);
    bus(1'b1, 32'(OFF_IRQ_EN), 32'h1);
    cyc(2);
    chk("irq_on", irq, 32'h1);
    bus(1'b1, 32'(OFF_IRQ_CLR), 32'h1);
    cyc(2);
    chk("irq_clr", irq, 32'h0);
    chk("flt_hold", flt_pin, 32'h1);
    // a hold shorter than the clear time leaves the fault latched
    dis_val <= 1'b1;
    cyc(100);
    dis_val <= 1'b0;
    cyc(8);
    chk("short", flt_pin, 32'h1);
    dis_val <= 1'b1;
    cyc(220);
    chk("flt_clr", flt_pin, 32'h0);
    dis_val <= 1'b0;
    wait_hi(0, COOL_N + 20);
    chk("recover", module_ready, 32'h1);
    // live status after recovery: laser, serial, ready, high power, both rates, run state
    bus(1'b0, 32'(OFF_STATUS), 32'h0);
    chk("status", rd, 32'h000001fc);
    // only the ready event has been raised since the last clear
    bus(1'b0, 32'(OFF_IRQ_STS), 32'h0);
    chk("irq_sts", rd, 32'h00000004);
    rstn <= 1'b0;
    cyc(3);
    chk("rst_laser", laser_on, 32'h0);
    final_report;
  end

  // watchdog: the sequence needs about 600 cycles
  initial
  begin
    cyc(20000);
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
